// ==== hw/rx_mac_pkg.sv ====
// Constants and types for the receive side of the MAC interface
package rx_mac_pkg;
  typedef enum logic [1:0] {mode_mii, mode_rmii, mode_serial} mode_t;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int HB_TIME_NS = 1000;
  localparam int HB_CYCLES = (HB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Receive clock synthesis from reference edges: add INC per edge, toggle at MOD
  localparam logic [3:0] DIV_MII100_INC = 4'h1;
  localparam logic [3:0] DIV_MII100_MOD = 4'h1;
  localparam logic [3:0] DIV_MII10_INC = 4'h1;
  localparam logic [3:0] DIV_MII10_MOD = 4'hA;
  localparam logic [3:0] DIV_SER_INC = 4'h2;
  localparam logic [3:0] DIV_SER_MOD = 4'h5;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ERRCNT = 4'h8;

  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SPEED100_BIT = 2;
  localparam int CTRL_FULL_DUPLEX_BIT = 3;
  localparam int CTRL_HB_EN_BIT = 4;
  localparam logic [1:0] CTRL_MODE_RMII = 2'h1;
  localparam logic [1:0] CTRL_MODE_SERIAL = 2'h2;

  // Status fields
  localparam int STAT_CRS_BIT = 0;
  localparam int STAT_DV_BIT = 1;
  localparam int STAT_COL_BIT = 2;
  localparam int STAT_ER_BIT = 3;
  localparam int STAT_HB_BIT = 4;

  // Reset values and error count limit
  localparam logic RST_SPEED100 = 1'b1;
  localparam logic RST_FULL_DUPLEX = 1'b0;
  localparam logic RST_HB_EN = 1'b1;
  localparam logic [15:0] ERRCNT_MAX = 16'hFFFF;
endpackage : rx_mac_pkg

// ==== hw/rx_mac_if.sv ====
// Receive pins, reference clock copy and Wishbone control of the MAC interface
//
// Contract
// - MII drives recovered receive clock, 25 MHz at 100 Mb/s, 2.5 MHz at 10.
// - RMII leaves receive clock unused; everything timed from 50 MHz reference.
// - Serial 10 Mb/s mode drives a 10 MHz recovered receive clock.
// - MII data valid high only while the nibble carries valid data.
// - RMII data valid is synchronous and independent of carrier sense.
// - Serial mode does not use data valid or receive error.
// - MII 100 Mb/s raises receive error on invalid symbol inside packet.
// - RMII 100 Mb/s raises receive error on media error while data valid.
// - On receive error the passed data is corrupted; MAC may ignore error.
// - MII drives nibble data synchronous to receive clock, valid with valid flag.
// - RMII drives dibit data synchronous to the 50 MHz reference.
// - Serial mode drives bit 0 only, valid while carrier high; upper bits unused.
// - MII and serial carrier high while medium busy; serial carrier frames data.
// - RMII drives combined carrier sense and data valid per RMII.
// - MII half duplex raises collision on simultaneous transmit and receive.
// - 10 Mb/s half duplex with heartbeat pulses collision about 1 us after transmit; code holds col for 1 us from two cycles after transmit, never in RMII.
// - Full duplex holds collision low and gives no heartbeat.
// - Serial mode raises collision on simultaneous transmit and receive.
// - Reference clock copy is driven out for other system parts.
//
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module rx_mac_if
  import rx_mac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic ref_clock_in,
  input wire logic medium_busy,
  input wire logic tx_active,
  input wire logic line_valid,
  input wire logic [3:0] line_data,
  input wire logic line_err,
  output logic line_ready,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  output logic ref_clock_out,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  typedef struct packed {
    logic ref_s1;
    logic ref_s2;
    logic ref_p;
    logic ref_out;
    logic [3:0] acc;
    logic rx_clk;
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic crs;
    logic col;
    logic dibit_ph;
    logic tx_prev;
    logic [3:0] hb_cnt;
    mode_t mode;
    logic speed100;
    logic full_dup;
    logic hb_en;
    logic ack;
    logic [31:0] dat;
    logic [15:0] err_cnt;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic tick;

  function automatic logic [3:0] div_inc(input mode_t m, input logic fast);
    if (m == mode_serial) begin
      div_inc = DIV_SER_INC;
    end else if (fast) begin
      div_inc = DIV_MII100_INC;
    end else begin
      div_inc = DIV_MII10_INC;
    end
  endfunction : div_inc

  function automatic logic [3:0] div_mod(input mode_t m, input logic fast);
    if (m == mode_serial) begin
      div_mod = DIV_SER_MOD;
    end else if (fast) begin
      div_mod = DIV_MII100_MOD;
    end else begin
      div_mod = DIV_MII10_MOD;
    end
  endfunction : div_mod

  function automatic mode_t decode_mode(input logic [1:0] v);
    if (v == CTRL_MODE_RMII) begin
      decode_mode = mode_rmii;
    end else if (v == CTRL_MODE_SERIAL) begin
      decode_mode = mode_serial;
    end else begin
      decode_mode = mode_mii;
    end
  endfunction : decode_mode

  always_comb begin
    logic ref_edge;
    logic ref_rise;
    logic [4:0] acc_sum;
    logic toggle;
    logic err_ev;
    logic hb_ok;
    logic wr;
    logic [31:0] rdat;
    ref_edge = 1'b0;
    ref_rise = 1'b0;
    acc_sum = 5'h00;
    toggle = 1'b0;
    err_ev = 1'b0;
    hb_ok = 1'b0;
    wr = 1'b0;
    rdat = 32'h0000_0000;
    s_d = s_q;
    tick = 1'b0;

    // Reference sampled through two flops before use
    s_d.ref_s1 = ref_clock_in;
    s_d.ref_s2 = s_q.ref_s1;
    s_d.ref_p = s_q.ref_s2;
    ref_edge = s_q.ref_s2 ^ s_q.ref_p;
    ref_rise = s_q.ref_s2 & ~s_q.ref_p;
    s_d.ref_out = s_q.ref_s2;

    case (s_q.mode)
      mode_rmii: begin
        // receive clock idle, timed by reference
        s_d.rx_clk = 1'b0;
        s_d.acc = 4'h0;
        tick = ref_rise;
      end
      default: begin
        if (ref_edge) begin
          acc_sum = {1'b0, s_q.acc} + {1'b0, div_inc(s_q.mode, s_q.speed100)};
          if (acc_sum >= {1'b0, div_mod(s_q.mode, s_q.speed100)}) begin
            acc_sum = acc_sum - {1'b0, div_mod(s_q.mode, s_q.speed100)};
            toggle = 1'b1;
          end
          s_d.acc = acc_sum[3:0];
        end
        if (toggle) begin
          s_d.rx_clk = ~s_q.rx_clk;
        end
        tick = toggle & s_q.rx_clk;
      end
    endcase

    // Outputs launched on falling receive clock or rising reference
    if (tick) begin
      if (line_valid) begin
        err_ev = line_err & s_q.speed100 & (s_q.mode != mode_serial);
        case (s_q.mode)
          mode_rmii: begin
            s_d.rxd = {2'b00, line_data[1:0] ^ {2{line_err}}};
          end
          mode_serial: begin
            s_d.rxd = {3'b000, line_data[0]};
          end
          default: begin
            s_d.rxd = line_data ^ {4{line_err}};
          end
        endcase
        s_d.rx_dv = (s_q.mode != mode_serial);
        s_d.rx_er = err_ev;
        s_d.dibit_ph = ~s_q.dibit_ph;
      end else begin
        s_d.rxd = 4'h0;
        s_d.rx_dv = 1'b0;
        s_d.rx_er = 1'b0;
        s_d.dibit_ph = 1'b0;
      end
      if (s_q.mode == mode_rmii) begin
        // carrier, then toggling while data drains
        s_d.crs = medium_busy | (line_valid & s_q.dibit_ph);
      end else begin
        s_d.crs = medium_busy;
      end
    end

    s_d.tx_prev = tx_active;
    hb_ok = ~s_q.speed100 & ~s_q.full_dup & s_q.hb_en & (s_q.mode != mode_rmii);
    if (s_q.tx_prev & ~tx_active & hb_ok) begin
      s_d.hb_cnt = 4'(HB_CYCLES);
    end else if (s_q.hb_cnt != 4'h0) begin
      s_d.hb_cnt = s_q.hb_cnt - 4'h1;
    end
    if (s_q.full_dup | (s_q.mode == mode_rmii)) begin
      s_d.col = 1'b0;
      s_d.hb_cnt = 4'h0;
    end else begin
      s_d.col = (medium_busy & tx_active) | (s_q.hb_cnt != 4'h0);
    end

    // Wishbone classic slave, one wait state
    s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack;
    if (wb_adr_i == REG_CTRL) begin
      rdat[CTRL_MODE_LSB +: 2] = (s_q.mode == mode_rmii) ? CTRL_MODE_RMII :
                                 (s_q.mode == mode_serial) ? CTRL_MODE_SERIAL : 2'h0;
      rdat[CTRL_SPEED100_BIT] = s_q.speed100;
      rdat[CTRL_FULL_DUPLEX_BIT] = s_q.full_dup;
      rdat[CTRL_HB_EN_BIT] = s_q.hb_en;
    end else if (wb_adr_i == REG_STATUS) begin
      rdat[STAT_CRS_BIT] = s_q.crs;
      rdat[STAT_DV_BIT] = s_q.rx_dv;
      rdat[STAT_COL_BIT] = s_q.col;
      rdat[STAT_ER_BIT] = s_q.rx_er;
      rdat[STAT_HB_BIT] = (s_q.hb_cnt != 4'h0);
    end else if (wb_adr_i == REG_ERRCNT) begin
      rdat[15:0] = s_q.err_cnt;
    end
    if (wb_cyc_i & wb_stb_i & ~s_q.ack & ~wb_we_i) begin
      s_d.dat = rdat;
    end
    if (wr & (wb_adr_i == REG_CTRL) & wb_sel_i[0]) begin
      s_d.mode = decode_mode(wb_dat_i[CTRL_MODE_LSB +: 2]);
      s_d.speed100 = wb_dat_i[CTRL_SPEED100_BIT];
      s_d.full_dup = wb_dat_i[CTRL_FULL_DUPLEX_BIT];
      s_d.hb_en = wb_dat_i[CTRL_HB_EN_BIT];
    end
    // Error count: clear restarts the count, and a same-cycle error counts as one
    if (wr & (wb_adr_i == REG_ERRCNT)) begin
      s_d.err_cnt = {15'h0000, err_ev};
    end else if (err_ev & (s_q.err_cnt != ERRCNT_MAX)) begin
      s_d.err_cnt = s_q.err_cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.mode <= mode_mii;
      s_q.speed100 <= RST_SPEED100;
      s_q.full_dup <= RST_FULL_DUPLEX;
      s_q.hb_en <= RST_HB_EN;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign line_ready = tick & line_valid & clk_en;
  assign rx_clk = s_q.rx_clk;
  assign rxd = s_q.rxd;
  assign rx_dv = s_q.rx_dv;
  assign rx_er = s_q.rx_er;
  assign crs = s_q.crs;
  assign col = s_q.col;
  assign ref_clock_out = s_q.ref_out;
  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
endmodule : rx_mac_if
`default_nettype wire

// ==== tb/line_src.sv ====
// Line-side unit source that holds each offer until taken
`timescale 1ns/100ps
`default_nettype none
module line_src (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [3:0] dd,
  input wire logic de,
  input wire logic line_ready,
  output logic line_valid,
  output logic [3:0] line_data,
  output logic line_err
);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      line_valid <= 1'b0;
      line_data <= 4'h0;
      line_err <= 1'b0;
    end else if (line_valid && line_ready) begin
      line_valid <= 1'b0;
      // Released lines show no stale unit
      line_data <= ~line_data;
      line_err <= ~line_err;
    end else if (go) begin
      line_valid <= 1'b1;
      line_data <= dd;
      line_err <= de;
    end
  end
endmodule : line_src
`default_nettype wire

// ==== tb/rx_mac_chk.sv ====
// Port checker for the receive MAC interface
`timescale 1ns/100ps
`default_nettype none
module rx_mac_chk
  import rx_mac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic ref_clock_in,
  input wire logic medium_busy,
  input wire logic tx_active,
  input wire logic [3:0] line_data,
  input wire logic line_err,
  input wire logic line_ready,
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic col,
  input wire logic ref_clock_out,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o
);
  logic [4:0] ctl_q;
  // Shadow of the control register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctl_q <= 5'h14;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      ctl_q <= {wb_dat_i[4:2], wb_dat_i[1:0] == 2'h3 ? 2'h0 : wb_dat_i[1:0]};
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  chk_ack_wait: assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ref_copy:
    assert property ($past(nrst) && $past(nrst, 2) && $past(nrst, 3) && $past(clk_en) && $past(clk_en, 2)
      && $past(clk_en, 3) |-> ref_clock_out == $past(ref_clock_in, 3))
    else $error("clock copy");
  chk_rmii_clk:
    assert property ((ctl_q[1:0] == 2'h1) [*3] |-> !rx_clk) else $error("rmii clock");
  chk_serial_quiet:
    assert property ((ctl_q[1:0] == 2'h2) [*3] |-> !rx_dv && !rx_er) else $error("serial dv");
  chk_mii_data:
    assert property (line_ready && ctl_q[1:0] == 2'h0 |=> rx_dv && rx_er == ($past(line_err) && ctl_q[2])
      && rxd == ($past(line_err) ? ~$past(line_data) : $past(line_data))) else $error("mii data");
  chk_rmii_data:
    assert property (line_ready && ctl_q[1:0] == 2'h1 |=> rx_dv && rx_er == ($past(line_err) && ctl_q[2])
      && rxd[1:0] == ($past(line_err) ? ~$past(line_data[1:0]) : $past(line_data[1:0]))) else $error("rmii data");
  chk_col_overlap:
    assert property (clk_en && !ctl_q[3] && ctl_q[1:0] != 2'h1 && medium_busy && tx_active |=> col)
    else $error("no col");
  chk_col_fdx:
    assert property (ctl_q[3] && $past(ctl_q[3]) |-> !col) else $error("fdx col");
  chk_rmii_nocol:
    assert property (ctl_q[1:0] == 2'h1 && $past(ctl_q[1:0]) == 2'h1 |-> !col) else $error("rmii col");
  chk_heartbeat:
    assert property (ctl_q[4:1] == 4'h8 && ctl_q[0] == 1'b0 && $fell(tx_active) |-> ##3 col [*8])
    else $error("heartbeat");
endmodule : rx_mac_chk
bind rx_mac_if rx_mac_chk i_rx_mac_chk (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the receive MAC interface
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rx_mac_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, ref_clock_in = 1'b0, medium_busy = 1'b0, tx_active = 1'b0;
  logic clk_en = 1'b1;
  logic go = 1'b0, de = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] dd = 4'h0, wb_adr_i = 4'h0, wb_sel_i = 4'h0, line_data, rxd;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic line_valid, line_err, line_ready, rx_clk, rx_dv, rx_er, crs, col, ref_clock_out, wb_ack_o;
  logic [15:0] sd = 16'h89E9;
  logic [31:0] cfg [4] = '{32'h14, 32'h10, 32'h12, 32'h15};
  int errors = 0, n_tests = 0, cyc = 0, n_err = 0;
  always #50 ref_clk = ~ref_clk;
  initial #137 forever #400 ref_clock_in = ~ref_clock_in;
  rx_mac_if i_rx_mac_if (.*);
  line_src i_line_src (.*);
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  task automatic send(input logic [3:0] d, input logic e, input logic [1:0] m);
    logic [3:0] k;
    k = (m == 2'h1) ? 4'h3 : (m == 2'h2) ? 4'h1 : 4'hF;
    go <= 1'b1;
    dd <= d;
    de <= e;
    @(posedge ref_clk);
    go <= 1'b0;
    do @(negedge ref_clk); while (line_ready !== 1'b1);
    @(negedge ref_clk);
    check("rxd", (e ? ~d : d) & k, rxd & k);
    check("rx_dv", m != 2'h2, rx_dv);
    check("rx_er", e, rx_er);
    check("crs", 1, crs);
    @(posedge ref_clk);
  endtask : send
  task automatic coll(input logic [31:0] c, input logic b, input int exp);
    int n;
    n = 0;
    wb(1, REG_CTRL, c, 4'hF);
    medium_busy <= b;
    tx_active <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(negedge ref_clk);
      n += (col === 1'b1);
      @(posedge ref_clk);
      if (i == 3) begin
        medium_busy <= 1'b0;
        tx_active <= 1'b0;
      end
    end
    check("col_cycles", exp, n);
  endtask : coll
  task automatic rx_period(input int exp);
    int n;
    n = 0;
    do @(negedge ref_clk); while (rx_clk !== 1'b0);
    do @(negedge ref_clk); while (rx_clk !== 1'b1);
    do begin
      @(negedge ref_clk);
      n++;
    end while (rx_clk !== 1'b0);
    do begin
      @(negedge ref_clk);
      n++;
    end while (rx_clk !== 1'b1);
    check("rx_clk_period", exp, n);
  endtask : rx_period
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    wb(0, REG_CTRL, 0, 4'hF);
    check("ctrl", 32'h14, r);
    wb(1, REG_CTRL, 32'h0F, 4'h0);
    wb(0, REG_CTRL, 0, 4'hF);
    check("ctrl_sel", 32'h14, r);
    wb(0, 4'hC, 0, 4'hF);
    check("unmapped", 0, r);
    wb(1, REG_ERRCNT, 0, 4'hF);
    wb(0, REG_ERRCNT, 0, 4'hF);
    check("errcnt", 0, r);
    for (int k = 0; k < 4; k++) begin
      wb(1, REG_CTRL, cfg[k], 4'hF);
      medium_busy <= 1'b1;
      for (int i = 0; i < 12; i++) begin
        sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
        n_err += sd[4] & cfg[k][2] & ~cfg[k][1];
        send(sd[3:0], sd[4] & cfg[k][2] & ~cfg[k][1], cfg[k][1:0]);
      end
      if (cfg[k][2:0] == 3'h0) begin
        // Slow receive clock leaves room to read the live flags
        wb(0, REG_STATUS, 0, 4'hF);
        check("status_busy", (1 << STAT_CRS_BIT) | (1 << STAT_DV_BIT), r);
      end
      medium_busy <= 1'b0;
      repeat (400) @(negedge ref_clk);
      check("dv_idle", 0, rx_dv);
      check("crs_idle", 0, crs);
      // Reference is 8 cycles: MII copies it, 10 Mb/s MII is a tenth, serial 10/25
      if (cfg[k][1:0] == 2'h1) check("rx_clk_rmii", 0, rx_clk);
      else rx_period((cfg[k][1:0] == 2'h2) ? 20 : cfg[k][2] ? 8 : 80);
      @(posedge ref_clk);
      wb(0, REG_STATUS, 0, 4'hF);
      check("status_idle", 0, r);
    end
    wb(0, REG_ERRCNT, 0, 4'hF);
    check("errcnt_sum", n_err, r);
    coll(32'h14, 1'b1, 4);
    coll(32'h10, 1'b0, 10);
    coll(32'h18, 1'b1, 0);
    coll(32'h02, 1'b1, 4);
    // MAC derives collision from carrier itself
    coll(32'h15, 1'b1, 0);
    // Clock enable low freezes every output but line_ready, which it holds low
    clk_en <= 1'b0;
    @(posedge ref_clk);
    r = {28'h0000000, rx_clk, ref_clock_out, col, crs};
    repeat (20) @(posedge ref_clk);
    check("frozen", r, {28'h0000000, rx_clk, ref_clock_out, col, crs});
    clk_en <= 1'b1;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
